// ### rtl/spmc_top.sv
// Purpose: one master channel of a synchronous serial unit, direct memory mode, APB registers
// Assumes: serial_data_in synchronous to pclk; frames of 2 to 32 data bits
// Notes: interrupt outputs are one-cycle pulses; software handshakes via status bits
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module spmc_top (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Serial side
  input  wire logic              serial_data_in,
  output spmc_pkg::spmc_pins_t   serial_pins,
  // Channel events
  output spmc_pkg::spmc_irq_t    irq
);
  import spmc_pkg::*;
  `include "spmc_cfg.svh"

  typedef struct packed {
    logic [`SPMC_NCFG-1:0][31:0] cfg;
    spmc_state_t st;
    logic        chen;
    logic        en_q;
    logic        tx_valid;
    logic        rx_valid;
    logic        par_err;
    logic        dcs_err;
    logic        cs_active;
    logic        run;
    logic        dly_load;
    logic [12:0] dly_val;
    logic [31:0] tx_data;
    logic [31:0] rx_data;
    logic [32:0] tx_sh;
    logic [32:0] rx_sh;
    logic [7:0]  frame_cnt;
    logic [6:0]  edge_cnt;
    spmc_pins_t  pins;
    spmc_irq_t   irq;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } spmc_regs_t;

  spmc_regs_t r, next_r;

  // Bit reversal for LSB-first framing
  function automatic logic [31:0] spmc_rev(input logic [31:0] x);
    logic [31:0] y;
    y = '0;
    for (int i = 0; i < 32; i++)
      y[i] = x[31-i];
    return y;
  endfunction : spmc_rev

  // Writable bits of a configuration word
  function automatic logic [31:0] spmc_mask(input logic [7:0] off);
    case (off)
      `SPMC_OFF_CTL0:  return `SPMC_MASK_CTL0;
      `SPMC_OFF_CTL1:  return `SPMC_MASK_CTL1;
      `SPMC_OFF_CTL2:  return `SPMC_MASK_CTL2;
      `SPMC_OFF_CFG0:  return `SPMC_MASK_CFG0;
      `SPMC_OFF_CFG1:  return `SPMC_MASK_CFG1;
      `SPMC_OFF_CFG2:  return `SPMC_MASK_CFG2;
      `SPMC_OFF_CFG3:  return `SPMC_MASK_CFG3;
      `SPMC_OFF_CFG4:  return `SPMC_MASK_CFG4;
      `SPMC_OFF_CFSET: return `SPMC_MASK_CFSET;
      `SPMC_OFF_SSEL:  return `SPMC_MASK_SSEL;
      default:         return `SPMC_MASK_DLY;
    endcase
  endfunction : spmc_mask

  // Field views of the configuration words
  logic [31:0] ctl0, ctl1, ctl2, cfg0, cfg1, cfg2, cfg3, ssel;
  logic        en, master_slave_select, select_input_enable, sample_shift, default_clock_level, output_level_select, select_polarity, consistency_check_enable, internal_loopback;
  logic        txe, rxe, fcce, iere, ifee, irxe, itxe;
  logic        cpol, cpha, lsbf, icls, csri, fidl, ps, par_en, cs_ret;
  logic [5:0]  fl;
  logic [5:0]  nb;
  logic [7:0]  fcount;
  logic [11:0] seup, hold, idle_t, inda;

  assign ctl0   = r.cfg[`SPMC_OFF_CTL0 >> 2];
  assign ctl1   = r.cfg[`SPMC_OFF_CTL1 >> 2];
  assign ctl2   = r.cfg[`SPMC_OFF_CTL2 >> 2];
  assign cfg0   = r.cfg[`SPMC_OFF_CFG0 >> 2];
  assign cfg1   = r.cfg[`SPMC_OFF_CFG1 >> 2];
  assign cfg2   = r.cfg[`SPMC_OFF_CFG2 >> 2];
  assign cfg3   = r.cfg[`SPMC_OFF_CFG3 >> 2];
  assign ssel   = r.cfg[`SPMC_OFF_SSEL >> 2];
  assign en     = ctl0[`SPMC_EN];
  assign master_slave_select  = ctl1[`SPMC_MASTER_SLAVE_SELECT];
  assign select_input_enable   = ctl1[`SPMC_SELECT_INPUT_ENABLE];
  assign sample_shift   = ctl1[`SPMC_SAMPLE_SHIFT];
  assign default_clock_level    = ctl1[`SPMC_CKR];
  assign output_level_select   = ctl1[`SPMC_OUTPUT_LEVEL_SELECT];
  assign select_polarity    = ctl1[`SPMC_CSP];
  assign consistency_check_enable    = ctl2[`SPMC_DCS];
  assign internal_loopback    = ctl2[`SPMC_LBM];
  assign txe    = cfg0[`SPMC_TXE];
  assign rxe    = cfg0[`SPMC_RXE];
  assign fcce   = cfg0[`SPMC_FCCE];
  assign iere   = cfg0[`SPMC_IERE];
  assign ifee   = cfg0[`SPMC_IFEE];
  assign irxe   = cfg0[`SPMC_IRXE];
  assign itxe   = cfg0[`SPMC_ITXE];
  assign cpol   = cfg1[`SPMC_CPOL];
  assign cpha   = cfg1[`SPMC_CPHA];
  assign lsbf   = cfg1[`SPMC_DIR];
  assign icls   = cfg1[`SPMC_ICLS];
  assign csri   = cfg1[`SPMC_CSRI];
  assign fidl   = cfg1[`SPMC_FIDL];
  assign ps     = cfg1[`SPMC_PS];
  assign par_en = cfg1[`SPMC_DECHK] != 2'h0;
  assign cs_ret = csri || !ssel[`SPMC_JOBEN];
  assign seup   = r.cfg[`SPMC_OFF_SEUP >> 2][`SPMC_DLY];
  assign hold   = r.cfg[`SPMC_OFF_HOLD >> 2][`SPMC_DLY];
  assign idle_t = r.cfg[`SPMC_OFF_IDLE >> 2][`SPMC_DLY];
  assign inda   = r.cfg[`SPMC_OFF_INDA >> 2][`SPMC_DLY];
  assign fcount = r.cfg[`SPMC_OFF_CFSET >> 2][7:0];

  // Frame length clamped to what the 32-bit data registers hold
  always_comb
  begin
    if (cfg2[`SPMC_FLEN] < 8'h02)
      fl = 6'h02;
    else if (cfg2[`SPMC_FLEN] > 8'h20)
      fl = 6'h20;
    else
      fl = cfg2[5:0];
    nb = fl + {5'h00, par_en};
  end

  // Transmit and receive word shaping: order, length and parity
  logic [31:0] dmask, dm, rx_raw, rx_word;
  logic [32:0] tx_load;
  logic        tx_par, rx_bad_par;
  always_comb
  begin
    dmask   = ~(32'hffff_ffff << fl);
    dm      = r.tx_data & dmask;
    tx_par  = ^dm ^ ~ps;
    tx_load = {(lsbf ? spmc_rev(dm) : dm << (6'h20 - fl)), 1'b0};
    if (par_en)
      tx_load = tx_load | (33'h0_0000_0001 << (6'h20 - fl));
    if (par_en && !tx_par)
      tx_load = {tx_load[32:1], 1'b0} & ~(33'h0_0000_0001 << (6'h20 - fl));
    rx_raw  = (par_en ? r.rx_sh[32:1] : r.rx_sh[31:0]) & dmask;
    rx_word = lsbf ? spmc_rev(rx_raw) >> (6'h20 - fl) : rx_raw;
    rx_bad_par = par_en && ((^rx_raw ^ r.rx_sh[0]) == ps);
  end

  // Edge arithmetic of the shift phase
  logic [6:0] e, s, nb2, last_e;
  logic       shift_ev, sample_shift_ev;
  always_comb
  begin
    e        = r.edge_cnt + 7'h01;
    s        = e - {6'h00, sample_shift};
    nb2      = {nb, 1'b0};
    last_e   = nb2 + {6'h00, sample_shift};
    shift_ev = (cpha ? e[0] : !e[0]) && (e < nb2);
    sample_shift_ev  = (s != 7'h00) && (s <= nb2) && (cpha ? !s[0] : s[0]);
  end

  // Helpers
  logic        tick, dly_exp, go, apb_setup, apb_acc, mapped, din;
  logic [31:0] rd_word;
  logic [12:0] gap;
  assign go        = en && !master_slave_select && !select_input_enable && r.chen;
  assign apb_setup = psel && !penable;
  assign apb_acc   = psel && penable && r.pready;
  assign mapped    = (paddr[1:0] == 2'h0) && (paddr <= `SPMC_OFF_RXDA);
  assign din       = internal_loopback ? r.pins.sout : serial_data_in;
  assign gap       = (cs_ret ? {1'b0, inda} : 13'h0000)
                   + (fidl ? {1'b0, idle_t} : 13'h0000);

  spmc_baud #(
    .DIV_W (12),
    .PRE_W (2)
  ) u_baud (
    .clk       (pclk),
    .rstn      (presetn),
    .run       (r.run),
    .prescaler (cfg3[`SPMC_PRCS]),
    .divider   (cfg3[`SPMC_CDIV]),
    .tick      (tick)
  );

  spmc_delay #(
    .W (13)
  ) u_delay (
    .clk     (pclk),
    .rstn    (presetn),
    .load    (r.dly_load),
    .value   (r.dly_val),
    .expired (dly_exp)
  );

  // Read multiplexer, sampled in the setup phase
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (paddr < (`SPMC_NCFG * 4))
      rd_word = r.cfg[paddr[5:2]];
    else if (paddr == `SPMC_OFF_CHEN)
      rd_word = {31'h0, r.chen};
    else if (paddr == `SPMC_OFF_STAT)
      rd_word = {16'h0, r.frame_cnt, 1'b0, r.dcs_err, r.par_err, r.rx_valid, r.tx_valid, r.st};
    else if (paddr == `SPMC_OFF_TXDA)
      rd_word = r.tx_data;
    else if (paddr == `SPMC_OFF_RXDA)
      rd_word = r.rx_data;
  end

  // Next-state logic: bus clears, sequencer, then bus sets so sets win
  always_comb
  begin
    next_r          = r;
    next_r.dly_load = 1'b0;
    next_r.irq      = '0;
    next_r.pready   = 1'b0;
    next_r.pslverr  = 1'b0;
    next_r.en_q     = en;
    if (apb_setup)
    begin
      next_r.pready  = 1'b1;
      next_r.pslverr = !mapped;
      next_r.prdata  = (mapped && !pwrite) ? rd_word : 32'h0000_0000;
    end
    if (apb_acc && mapped)
    begin
      if (pwrite && paddr < (`SPMC_NCFG * 4))
        next_r.cfg[paddr[5:2]] = pwdata & spmc_mask(paddr);
      if (pwrite && paddr == `SPMC_OFF_STAT)
      begin
        if (pwdata[`SPMC_ST_PERR])
          next_r.par_err = 1'b0;
        if (pwdata[`SPMC_ST_DERR])
          next_r.dcs_err = 1'b0;
      end
      if (!pwrite && paddr == `SPMC_OFF_RXDA)
        next_r.rx_valid = 1'b0;
    end
    // Data line goes to the chosen rest level when the unit is switched on
    if (en && !r.en_q)
      next_r.pins.sout = output_level_select;
    case (r.st)
      SPMC_IDLE:
      begin
        if (!icls)
          next_r.cs_active = 1'b0;
        if (go)
        begin
          next_r.st        = SPMC_TXREQ;
          next_r.frame_cnt = 8'h00;
          next_r.irq.tx    = itxe && txe;
        end
      end
      SPMC_TXREQ:
      begin
        if (!r.chen)
          next_r.st = SPMC_IDLE;
        else if (r.tx_valid || !txe)
        begin
          next_r.tx_valid  = 1'b0;
          next_r.tx_sh     = tx_load;
          next_r.rx_sh     = '0;
          next_r.cs_active = 1'b1;
          next_r.edge_cnt  = 7'h00;
          next_r.dly_load  = 1'b1;
          next_r.dly_val   = {1'b0, seup};
          next_r.pins.sck  = cpol;
          next_r.st        = SPMC_SETUP;
          // Phase 0 presents the first bit before the first edge
          if (!cpha && txe)
          begin
            next_r.pins.sout = tx_load[32];
            next_r.tx_sh     = tx_load << 1;
          end
        end
      end
      SPMC_SETUP:
      begin
        if (dly_exp)
        begin
          next_r.run = 1'b1;
          next_r.st  = SPMC_SHIFT;
        end
      end
      SPMC_SHIFT:
      begin
        if (tick)
        begin
          next_r.edge_cnt = e;
          if (e <= nb2)
            next_r.pins.sck = !r.pins.sck;
          if (shift_ev && txe)
          begin
            next_r.pins.sout = r.tx_sh[32];
            next_r.tx_sh     = r.tx_sh << 1;
          end
          if (sample_shift_ev)
            next_r.rx_sh = {r.rx_sh[31:0], din};
          // An extra half period closes the frame when sampling is shifted
          if (e == last_e)
          begin
            next_r.run      = 1'b0;
            next_r.dly_load = 1'b1;
            next_r.dly_val  = {1'b0, hold};
            next_r.st       = SPMC_HOLD;
          end
        end
      end
      SPMC_HOLD:
      begin
        if (dly_exp)
        begin
          next_r.frame_cnt = r.frame_cnt + 8'h01;
          if (cs_ret)
            next_r.cs_active = 1'b0;
          if (rxe)
          begin
            next_r.rx_data  = rx_word;
            next_r.rx_valid = 1'b1;
            next_r.irq.rx   = irxe;
            if (rx_bad_par)
              next_r.par_err = 1'b1;
            if (consistency_check_enable && rx_word != dm)
              next_r.dcs_err = 1'b1;
            next_r.irq.err = iere && (rx_bad_par || (consistency_check_enable && rx_word != dm));
          end
          if (r.frame_cnt + 8'h01 >= ((fcount == 8'h00) ? 8'h01 : fcount))
          begin
            next_r.irq.fe    = ifee;
            next_r.frame_cnt = 8'h00;
            if (!fcce)
              next_r.chen = 1'b0;
          end
          next_r.dly_load = 1'b1;
          next_r.dly_val  = gap;
          next_r.st       = SPMC_GAP;
        end
      end
      SPMC_GAP:
      begin
        if (dly_exp)
        begin
          if (go)
          begin
            next_r.st     = SPMC_TXREQ;
            next_r.irq.tx = itxe && txe;
          end
          else
            next_r.st = SPMC_IDLE;
        end
      end
      default:
        next_r.st = SPMC_IDLE;
    endcase
    // Switching the unit off aborts any frame at once
    if (!en)
    begin
      next_r.st        = SPMC_IDLE;
      next_r.run       = 1'b0;
      next_r.cs_active = 1'b0;
    end
    if (apb_acc && mapped && pwrite)
    begin
      if (paddr == `SPMC_OFF_CHEN)
        next_r.chen = pwdata[0];
      if (paddr == `SPMC_OFF_TXDA)
      begin
        next_r.tx_data  = pwdata;
        next_r.tx_valid = 1'b1;
      end
    end
    // Pins are rebuilt from state so every output stays a flop
    next_r.pins.cs = ~(({8{next_r.cs_active}} & ssel[`SPMC_CSR]) ^ {8{select_polarity}});
    if (!next_r.run && next_r.st != SPMC_SETUP)
      next_r.pins.sck = en ? cpol : default_clock_level;
  end

  // State register; priority field resets to the lowest level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r                               <= '0;
      r.cfg[`SPMC_OFF_CFG0 >> 2]      <= `SPMC_RST_CFG0;
      r.cfg[`SPMC_OFF_CFG2 >> 2]      <= `SPMC_RST_CFG2;
      r.pins.cs                       <= 8'hff;
    end
    else
      r <= next_r;
  end

  assign prdata      = r.prdata;
  assign pready      = r.pready;
  assign pslverr     = r.pslverr;
  assign serial_pins = r.pins;
  assign irq         = r.irq;
endmodule : spmc_top
`default_nettype wire

// ### rtl/spmc_cfg.svh
// Purpose: register offsets, field positions and reset values of the serial master channel
// Assumes: included by bare name after the package; offsets are APB byte addresses
// Notes: delay fields count pclk periods
// Function
// - Master mode needs select field 0 and select input enable held 0.
// - Sample-shift set moves the receive sample to the next clock edge.
// - Polarity and default level 0 keep the serial clock low when idle.
// - Output level 0 drives data low on enable; last bit held between frames.
// - Select polarity 0 makes chip selects active low, inactive high.
// - Unit runs only when enabled; consistency check and loop-back off at 0.
// - Priority field 7 means lowest level 8 and is the reset value.
// - Continuous bit 0 clears the channel enable after the last frame.
// - Error, frame end, receive and transmit interrupts fire only when enabled.
// - Phase 1 shifts data on odd clock edges, samples on even edges.
// - Bit order 0 sends and receives most significant bit first.
// - Idle level 0 keeps select inactive; return bit 1 negates after frames.
// - Frame idle bit 0 inserts no idle interval after a frame.
// - Safety protocol enable, format and first-frame mask at 0 do nothing.
// - Parity select 0 means odd parity; check mode 0 means no check.
// - Frame length field gives bits per frame; 0x20 is 32, the default.
// - Frame count field gives frames per activation.
// - Master alone makes the clock: unit clock over 4^prescaler times divider times 2.
// - Setup, hold and two inter-frame delays are 12-bit unit clock counts.
// - Job continue 0 ends job each frame; select bit 0 picks chip select 0.
`ifndef SPMC_CFG_SVH
`define SPMC_CFG_SVH
`define SPMC_OFF_CTL0  8'h00
`define SPMC_OFF_CTL1  8'h04
`define SPMC_OFF_CTL2  8'h08
`define SPMC_OFF_CFG0  8'h0c
`define SPMC_OFF_CFG1  8'h10
`define SPMC_OFF_CFG2  8'h14
`define SPMC_OFF_CFG3  8'h18
`define SPMC_OFF_CFG4  8'h1c
`define SPMC_OFF_SEUP  8'h20
`define SPMC_OFF_HOLD  8'h24
`define SPMC_OFF_IDLE  8'h28
`define SPMC_OFF_INDA  8'h2c
`define SPMC_OFF_CFSET 8'h30
`define SPMC_OFF_SSEL  8'h34
`define SPMC_OFF_CHEN  8'h38
`define SPMC_OFF_STAT  8'h3c
`define SPMC_OFF_TXDA  8'h40
`define SPMC_OFF_RXDA  8'h44
`define SPMC_NCFG      14
// Writable bits of each configuration word
`define SPMC_MASK_CTL0  32'h0000_0001
`define SPMC_MASK_CTL1  32'h0000_003f
`define SPMC_MASK_CTL2  32'h0000_0003
`define SPMC_MASK_CFG0  32'h0000_1ff7
`define SPMC_MASK_CFG1  32'h0000_0fff
`define SPMC_MASK_CFG2  32'h0000_00ff
`define SPMC_MASK_CFG3  32'h0003_0fff
`define SPMC_MASK_CFG4  32'h0000_0301
`define SPMC_MASK_DLY   32'h0000_0fff
`define SPMC_MASK_CFSET 32'h0000_00ff
`define SPMC_MASK_SSEL  32'h0001_00ff
`define SPMC_RST_CFG0   32'h0000_0070
`define SPMC_RST_CFG2   32'h0000_0020
// Field positions
`define SPMC_EN    0
`define SPMC_MASTER_SLAVE_SELECT 0
`define SPMC_SELECT_INPUT_ENABLE  1
`define SPMC_SAMPLE_SHIFT  2
`define SPMC_CKR   3
`define SPMC_OUTPUT_LEVEL_SELECT  4
`define SPMC_CSP   5
`define SPMC_DCS   0
`define SPMC_LBM   1
`define SPMC_TXE   0
`define SPMC_RXE   1
`define SPMC_PRIO  6:4
`define SPMC_FCCE  8
`define SPMC_IERE  9
`define SPMC_IFEE  10
`define SPMC_IRXE  11
`define SPMC_ITXE  12
`define SPMC_CPOL  0
`define SPMC_CPHA  1
`define SPMC_DIR   2
`define SPMC_ICLS  3
`define SPMC_CSRI  4
`define SPMC_FIDL  5
`define SPMC_PS    9
`define SPMC_DECHK 11:10
`define SPMC_FLEN  7:0
`define SPMC_CDIV  11:0
`define SPMC_PRCS  17:16
`define SPMC_DLY   11:0
`define SPMC_CSR   7:0
`define SPMC_JOBEN 16
`define SPMC_ST_TXV  3
`define SPMC_ST_RXV  4
`define SPMC_ST_PERR 5
`define SPMC_ST_DERR 6
`endif

// ### rtl/spmc_pkg.sv
// Purpose: shared types of the serial master channel
// Assumes: nothing
// Notes: offsets and fields live in spmc_cfg.svh
package spmc_pkg;

  // Channel sequencer states
  typedef enum logic [2:0] {
    SPMC_IDLE  = 3'b000,
    SPMC_TXREQ = 3'b001,
    SPMC_SETUP = 3'b010,
    SPMC_SHIFT = 3'b011,
    SPMC_HOLD  = 3'b100,
    SPMC_GAP   = 3'b101
  } spmc_state_t;

  // Serial side outputs
  typedef struct packed {
    logic       sck;
    logic       sout;
    logic [7:0] cs;
  } spmc_pins_t;

  // One-cycle event outputs
  typedef struct packed {
    logic err;
    logic fe;
    logic rx;
    logic tx;
  } spmc_irq_t;

endpackage : spmc_pkg

// ### rtl/spmc_baud.sv
// Purpose: half-period tick for the serial clock
// Assumes: run stays high for the whole frame
// Notes: a divider of 0 is treated as 1
`timescale 1ns/1ps
`default_nettype none
module spmc_baud #(
  parameter int DIV_W = 12,
  parameter int PRE_W = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Control
  input  wire logic             run,
  input  wire logic [PRE_W-1:0] prescaler,
  input  wire logic [DIV_W-1:0] divider,
  // Half-period pulse
  output logic                  tick
);
  localparam int CW = DIV_W + 2 * ((1 << PRE_W) - 1);
  typedef struct packed {
    logic [CW-1:0] cnt;
  } spmc_baud_t;
  spmc_baud_t r, next_r;
  logic [CW-1:0] half;

  // Half period is divider times 4^prescaler pclk cycles
  always_comb
  begin
    half = CW'(divider == '0 ? 1 : divider) << (2 * prescaler);
    tick = run && (r.cnt == half - CW'(1));
    next_r = r;
    if (!run || tick)
      next_r.cnt = '0;
    else
      next_r.cnt = r.cnt + CW'(1);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      r <= '0;
    else
      r <= next_r;
  end
endmodule : spmc_baud
`default_nettype wire

// ### rtl/spmc_delay.sv
// Purpose: one-shot pclk delay counter
// Assumes: load is a one-cycle pulse
// Notes: expired rises value+1 cycles after load
`timescale 1ns/1ps
`default_nettype none
module spmc_delay #(
  parameter int W = 13
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  // Status
  output logic              expired
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } spmc_delay_t;
  spmc_delay_t r, next_r;

  // Count down to zero; load masks expiry in its own cycle
  always_comb
  begin
    expired = !load && (r.cnt == '0);
    next_r = r;
    if (load)
      next_r.cnt = value;
    else if (r.cnt != '0)
      next_r.cnt = r.cnt - W'(1);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      r <= '0;
    else
      r <= next_r;
  end
endmodule : spmc_delay
`default_nettype wire

// ### dv/spmc_loop.sv
// Purpose: far side of the channel, a data-line loop-back
// Assumes: chip select 0 active low
// Notes: a released line shows the inverse of the last bit
`timescale 1ns/1ps
`default_nettype none
module spmc_loop (
  // Clock
  input  wire logic pclk,
  // Serial lines
  input  wire logic sel_n,
  input  wire logic sout,
  output logic      sin
);
  logic last = 1'b0;
  // Remember the last bit seen while selected
  always_ff @(posedge pclk)
    if (!sel_n) last <= sout;
  // Inverse when released, so a stale sample cannot pass for data
  assign sin = sel_n ? ~last : sout;
endmodule : spmc_loop
`default_nettype wire

// ### dv/spmc_monitor.sv
// Purpose: port checker of the serial master channel
// Assumes: bench selects chip select 0 only
// Notes: bound to spmc_top
`timescale 1ns/1ps
`default_nettype none
module spmc_monitor (
  // Clock and reset
  input wire logic                 pclk,
  input wire logic                 presetn,
  // APB
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pready,
  input wire logic                 pslverr,
  // Serial and events
  input wire spmc_pkg::spmc_pins_t serial_pins,
  input wire spmc_pkg::spmc_irq_t  irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Bus answers
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  // Serial clock only inside frames, low at rest
  a_sck_idle_low: assert property (serial_pins.cs == 8'hff |-> !serial_pins.sck)
    else $error("clock not low at rest");
  a_sck_in_frame: assert property (!$stable(serial_pins.sck) |-> serial_pins.cs != 8'hff)
    else $error("clock moved outside frame");
  a_sout_holds_idle: assert property (serial_pins.cs == 8'hff ##1 serial_pins.cs == 8'hff |-> $stable(serial_pins.sout))
    else $error("data moved between frames");
  a_cs_others_high: assert property (serial_pins.cs[7:1] == 7'h7f)
    else $error("unselected chip select active");
  // Transmit event is a single pulse; receive and transmit never in the same cycle
  a_tx_pulse: assert property (irq.tx |=> !irq.tx) else $error("transmit event held");
  a_rx_not_tx: assert property (irq.rx |-> !irq.tx) else $error("events collide");
endmodule : spmc_monitor
bind spmc_top spmc_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .serial_pins(serial_pins), .irq(irq));
`default_nettype wire

// ### dv/test_spmc_top.sv
// Purpose: self-checking bench of the serial master channel
// Assumes: loop-back partner; registers over APB
// Notes: events are counted per kind; waits are bounded
`timescale 1ns/1ps
`default_nettype none
`include "spmc_cfg.svh"
module test_spmc_top;
  import spmc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sin, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, wire_bits, wexp;
  logic        lsb_first = 1'b0;
  spmc_pins_t  pins;
  spmc_irq_t   irq;
  int          bad_count, total_checks, cyc, last_rise, period;
  int          ev [4];
  logic [7:0]  ca [11] = '{`SPMC_OFF_CTL1, `SPMC_OFF_CTL2, `SPMC_OFF_CTL0, `SPMC_OFF_CFG1, `SPMC_OFF_CFG3,
    `SPMC_OFF_CFG4, `SPMC_OFF_SEUP, `SPMC_OFF_HOLD, `SPMC_OFF_IDLE, `SPMC_OFF_INDA, `SPMC_OFF_SSEL};
  logic [31:0] cd [11] = '{32'h4, 32'h0, 32'h1, 32'h12, 32'h4, 32'h0, 32'h2, 32'h1, 32'h1, 32'h8, 32'h1};
  logic [31:0] words [4] = '{32'ha5c3_0f81, 32'h8000_0001, 32'h7ffe_fffe, 32'h1234_5678};
  spmc_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_data_in(sin), .serial_pins(pins), .irq(irq));
  spmc_loop partner (.pclk(pclk), .sel_n(pins.cs[0]), .sout(pins.sout), .sin(sin));
  initial
  begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  // Event counters and wire watchers
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    for (int b = 0; b < 4; b++)
      if (irq[b] === 1'b1) ev[b] <= ev[b] + 1;
  end
  always @(posedge pins.sck)
  begin
    period <= cyc - last_rise;
    last_rise <= cyc;
  end
  always @(negedge pins.sck) wire_bits <= {wire_bits[30:0], pins.sout};
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (e !== g)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer; waits for ready, bounded
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    chk("pready", 1, pready);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : bus
  task automatic wait_ev(input int b, input int t);
    for (int k = 0; k < 3000 && ev[b] < t; k++)
      @(posedge pclk);
    chk("event count", t, ev[b]);
  endtask : wait_ev
  // One activation of n frames; events on or polled status
  task automatic job(input logic [31:0] c0, input int n, input bit ien);
    int s;
    int t0;
    int f0;
    bus(1, `SPMC_OFF_CFG0, c0);
    bus(1, `SPMC_OFF_CFSET, n);
    s = ev[0] + ev[1] + ev[2] + ev[3];
    t0 = ev[0];
    f0 = ev[2];
    bus(1, `SPMC_OFF_CHEN, 1);
    for (int i = 0; i < n; i++)
    begin
      if (ien) wait_ev(0, t0 + i + 1);
      bus(1, `SPMC_OFF_TXDA, words[i]);
      rd = 0;
      if (ien) wait_ev(1, ev[1] + 1);
      for (int k = 0; k < 300 && rd[`SPMC_ST_RXV] !== 1'b1; k++)
        bus(0, `SPMC_OFF_STAT, 0);
      bus(0, `SPMC_OFF_RXDA, 0);
      chk("rx data", words[i], rd);
      for (int b = 0; b < 32; b++) wexp[b] = lsb_first ? words[i][31-b] : words[i][b];
      chk("wire bits", wexp, wire_bits);
      chk("cs after frame", 8'hff, pins.cs);
      chk("sck rest", 0, pins.sck);
      chk("sck period", 8, period);
    end
    if (ien) wait_ev(2, f0 + 1);
    bus(0, `SPMC_OFF_CHEN, 0);
    chk("channel enable", 0, rd);
    if (!ien) chk("gated events", s, ev[0] + ev[1] + ev[2] + ev[3]);
  endtask : job
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (50000) @(posedge pclk);
    bad_count++;
    give_verdict();
  end
  initial
  begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    bus(0, `SPMC_OFF_CFG0, 0);
    chk("priority reset", 32'h70, rd);
    bus(0, `SPMC_OFF_CFG2, 0);
    chk("length reset", 32'h20, rd);
    bus(0, 8'h48, 0);
    chk("unmapped error", 1, er);
    for (int i = 0; i < 11; i++)
      bus(1, ca[i], cd[i]);
    chk("sout after enable", 0, pins.sout);
    job(32'h1e70 | 32'h3, 4, 1);
    job(32'h0073, 1, 0);
    lsb_first = 1'b1;
    bus(1, `SPMC_OFF_CFG1, 32'h16);
    job(32'h0073, 1, 0);
    give_verdict();
  end
endmodule : test_spmc_top
`default_nettype wire
